// ---- verilog/scid_pkg.sv ----
package scid_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned OFF_MS       = 50;     // Waveform loss time.
  localparam int unsigned DIS_MS       = 10;     // De-energize time.
  localparam int unsigned MIN_PHASE_NS = 300;    // Least high or low.
  localparam int unsigned FREQ_MAX_HZ  = 700_000;
  localparam int unsigned OFF_CYCLES   = (CLK_HZ / 1000) * OFF_MS;
  localparam int unsigned DIS_CYCLES   = (CLK_HZ / 1000) * DIS_MS;
  localparam int unsigned MIN_PHASE_CYC =
    (MIN_PHASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FREQ_MAX_PER = CLK_HZ / FREQ_MAX_HZ;

  // ****************************************************************
  // Widths and scales.
  // ****************************************************************
  localparam int unsigned CNT_W  = 23;   // Holds a 20 Hz period.
  localparam int unsigned DIS_W  = 20;
  localparam int unsigned TQ_W   = 16;
  localparam int unsigned VEL_W  = 16;
  localparam int unsigned DUTY_SH = 10;  // Duty in 1/1024 steps.
  localparam logic [39:0] DUTY_ONE  = 40'h0000000400;
  localparam logic [39:0] DUTY_HALF = 40'h0000000200;
  localparam logic [39:0] TQ_FULL   = 40'h0000007fff;
  localparam logic [39:0] FREQ_K    = TQ_FULL * FREQ_MAX_PER;

  // ****************************************************************
  // Command modes, one-hot.
  // ****************************************************************
  typedef enum logic [4:0] {
    MODE_BIPOLAR  = 5'h01,
    MODE_UNIPOLAR = 5'h02,
    MODE_FREQ     = 5'h04,
    MODE_SELVEL   = 5'h08,
    MODE_SPIN     = 5'h10
  } scid_mode_t;

  // ****************************************************************
  // Controller register map and fields.
  // ****************************************************************
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_PERIOD = 2'h1;
  localparam logic [1:0] REG_HIGH   = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_DIR   = 1;
  localparam int unsigned CTRL_RUN   = 2;
  localparam int unsigned CTRL_LEVEL = 3;
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [22:0] PERIOD_RST = 23'h0003e8;
  localparam logic [22:0] HIGH_RST   = 23'h0001f4;

endpackage : scid_pkg

// ---- verilog/scid_link_if.sv ----
interface scid_link_if;
  logic enable;       // High energizes the motor.
  logic sel_a;        // Direction select, or velocity select bit.
  logic wave;         // Command waveform, or velocity select bit.
  logic fb_status;    // feedback_status_output from the device.

  modport device (input enable, input sel_a, input wave,
                  output fb_status);
  modport controller (output enable, output sel_a, output wave,
                      input fb_status);
endinterface : scid_link_if

// ---- verilog/scid_device.sv ----
// Summary of operation
// - Bipolar duty inside deadband gives zero torque.
// - Slope outside deadband grows with deadband width.
// - Unipolar torque proportional to duty.
// - Static low or high means zero torque.
// - Unipolar: select high CW, low CCW.
// - PWM from 20 Hz to 30 kHz decoded.
// - No edges for 50 ms: zero torque.
// - Controller keeps phases at least 300 ns.
// - Frequency mode torque proportional to rate.
// - Frequency measured from 20 Hz to 700 kHz.
// - Pulse train stopped 50 ms: zero torque.
// - Frequency mode: select high CW, low CCW.
// - Enable high energizes, low disables motor.
// - De-energize completes within 10 ms.
// - Selected velocity: sample inputs, ramp to pick.
// - Select high, waveform low picks velocity one.
// - Input change retargets ramp at once.
// - User should store one zero velocity.
// - Spin mode ramps at power-up, ignores inputs.
// - Bipolar: below half CW, above half CCW.
module scid_device #(
  parameter int unsigned OFF_CYC = scid_pkg::OFF_CYCLES, // Loss time.
  parameter int unsigned DIS_CYC = scid_pkg::DIS_CYCLES  // Disable time.
) (
  input  wire logic                            i_clk_sys,  // Clock.
  input  wire logic                            i_reset_n,  // Reset.
  input  wire scid_pkg::scid_mode_t            i_mode,     // Mode.
  input  wire logic [9:0]                      i_deadband, // Half width.
  input  wire logic [3:0][scid_pkg::VEL_W-1:0] i_sel_vel,  // Velocities.
  input  wire logic [scid_pkg::VEL_W-1:0]      i_spin_vel, // Spin target.
  input  wire logic [scid_pkg::VEL_W-1:0]      i_accel,    // Per cycle.
  scid_link_if.device                          link,       // Link pins.
  output logic signed [scid_pkg::TQ_W-1:0]     o_torque,   // +CW, -CCW.
  output logic signed [scid_pkg::VEL_W-1:0]    o_velocity, // Ramped.
  output logic                                 o_energized // Motor on.
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic                        wave_q;
    logic                        seen;
    logic                        meas;
    logic [scid_pkg::CNT_W-1:0]  cnt;
    logic [scid_pkg::CNT_W-1:0]  hi_cnt;
    logic [scid_pkg::CNT_W-1:0]  per;
    logic [scid_pkg::CNT_W-1:0]  hi;
    logic [scid_pkg::CNT_W-1:0]  idle;
    logic [scid_pkg::DIS_W-1:0]  dis;
    logic                        en_out;
    logic signed [scid_pkg::TQ_W-1:0]  tq;
    logic signed [scid_pkg::VEL_W-1:0] vel;
    logic                        fb;
  } scid_dev_state_t;

  scid_dev_state_t s_q;
  scid_dev_state_t s_d;

  // Guarded division; a zero divisor yields the largest value.
  function automatic logic [39:0] scid_div(input logic [39:0] a,
                                           input logic [39:0] b);
    scid_div = (b == 40'h0) ? {40{1'b1}} : a / b;
  endfunction : scid_div

  // Saturating increment of a period counter.
  function automatic logic [scid_pkg::CNT_W-1:0] scid_inc(
    input logic [scid_pkg::CNT_W-1:0] v);
    scid_inc = (&v) ? v : v + 1'b1;
  endfunction : scid_inc

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  logic                        rise;
  logic                        edge_seen;
  logic                        run;
  logic                        cw;
  logic [39:0]                 duty;
  logic [39:0]                 off;
  logic [39:0]                 mag;
  logic [1:0]                  idx;
  logic signed [scid_pkg::VEL_W-1:0] target;
  logic signed [scid_pkg::VEL_W:0]   gap;
  logic                        vel_mode;

  always_comb begin
    s_d       = s_q;
    rise      = link.wave & ~s_q.wave_q;
    edge_seen = link.wave ^ s_q.wave_q;
    vel_mode  = (i_mode == scid_pkg::MODE_SELVEL) ||
                (i_mode == scid_pkg::MODE_SPIN);
    s_d.wave_q = link.wave;

    // Period and high time are counted from rising edge to rising edge,
    // so one full period is measured per cycle of the waveform.
    s_d.cnt    = rise ? {{(scid_pkg::CNT_W-1){1'b0}}, 1'b1}
                      : scid_inc(s_q.cnt);
    s_d.hi_cnt = rise ? {{(scid_pkg::CNT_W-1){1'b0}}, 1'b1}
               : (link.wave ? scid_inc(s_q.hi_cnt) : s_q.hi_cnt);
    if (rise) begin
      s_d.per  = s_q.cnt;
      s_d.hi   = s_q.hi_cnt;
      s_d.seen = 1'b1;
      s_d.meas = s_q.seen; // The first edge gives no full period.
    end
    s_d.idle = edge_seen ? '0 : scid_inc(s_q.idle);
    // A static level has no edges and so falls into the same timeout.
    // A rising edge that lands with the loss still opens a new measurement.
    if (32'(s_q.idle) >= OFF_CYC) begin
      s_d.seen = rise;
      s_d.meas = 1'b0;
    end

    // Duty in 1/1024 steps of high time over period.
    duty = scid_div({17'h0, s_q.hi} << scid_pkg::DUTY_SH,
                    {17'h0, s_q.per});
    if (duty > scid_pkg::DUTY_ONE) begin
      duty = scid_pkg::DUTY_ONE;
    end

    // Torque magnitude and direction per mode.
    cw  = link.sel_a;
    off = '0;
    mag = '0;
    case (i_mode)
      scid_pkg::MODE_BIPOLAR: begin
        cw  = (duty < scid_pkg::DUTY_HALF);
        off = cw ? scid_pkg::DUTY_HALF - duty
                 : duty - scid_pkg::DUTY_HALF;
        if (off <= {30'h0, i_deadband}) begin
          mag = '0;
        end else begin
          // Span left after the deadband still reaches full scale.
          mag = scid_div((off - {30'h0, i_deadband}) * scid_pkg::TQ_FULL,
                         scid_pkg::DUTY_HALF - {30'h0, i_deadband});
        end
      end
      scid_pkg::MODE_UNIPOLAR: begin
        mag = (duty * scid_pkg::TQ_FULL) >> scid_pkg::DUTY_SH;
      end
      scid_pkg::MODE_FREQ: begin
        mag = scid_div(scid_pkg::FREQ_K, {17'h0, s_q.per});
      end
      default: begin
        mag = '0;
      end
    endcase
    if (mag > scid_pkg::TQ_FULL) begin
      mag = scid_pkg::TQ_FULL;
    end

    // Enable handling; spin mode ignores the enable line.
    run = (i_mode == scid_pkg::MODE_SPIN) || link.enable;
    if (run) begin
      s_d.dis    = '0;
      s_d.en_out = 1'b1;
    end else if (32'(s_q.dis) < DIS_CYC - 1) begin
      s_d.dis = s_q.dis + 1'b1;
    end else begin
      s_d.en_out = 1'b0;
    end

    // Torque is cut at once on disable or loss of the waveform.
    if (!run || !s_q.meas || vel_mode) begin
      s_d.tq = '0;
    end else begin
      s_d.tq = cw ? signed'(mag[scid_pkg::TQ_W-1:0])
                  : -signed'(mag[scid_pkg::TQ_W-1:0]);
    end

    // Velocity target; index read fresh every cycle.
    idx = {link.wave, link.sel_a};
    if (i_mode == scid_pkg::MODE_SPIN) begin
      target = signed'(i_spin_vel);
    end else if (i_mode == scid_pkg::MODE_SELVEL) begin
      target = signed'(i_sel_vel[idx]);
    end else begin
      target = '0;
    end
    gap = {target[scid_pkg::VEL_W-1], target}
        - {s_q.vel[scid_pkg::VEL_W-1], s_q.vel};
    if (!vel_mode || !run) begin
      s_d.vel = '0;
    end else if (gap > signed'({1'b0, i_accel})) begin
      s_d.vel = s_q.vel + signed'(i_accel);
    end else if (gap < -signed'({1'b0, i_accel})) begin
      s_d.vel = s_q.vel - signed'(i_accel);
    end else begin
      s_d.vel = target;
    end

    // Feedback shows energized, and at speed in velocity modes.
    s_d.fb = s_q.en_out && (!vel_mode || (s_q.vel == target));
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_torque       = s_q.tq;
  assign o_velocity     = s_q.vel;
  assign o_energized    = s_q.en_out;
  assign link.fb_status = s_q.fb;

endmodule : scid_device

// ---- verilog/scid_controller.sv ----
module scid_controller (
  input  wire logic         i_clk_sys, // Clock.
  input  wire logic         i_reset_n, // Reset.
  input  wire logic [1:0]   i_addr,    // Register index.
  input  wire logic [31:0]  i_wdata,   // Write data.
  input  wire logic         i_wr,      // Write strobe.
  input  wire logic         i_rd,      // Read strobe.
  output logic [31:0]       o_rdata,   // Read data, next cycle.
  scid_link_if.controller   link       // Link pins.
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_STATIC = 3'h1,
    ST_HIGH   = 3'h2,
    ST_LOW    = 3'h4
  } scid_ctl_st_t;

  typedef struct packed {
    scid_ctl_st_t st;
    logic [3:0]   ctrl;
    logic [22:0]  per;
    logic [22:0]  hi;
    logic [22:0]  cnt;
    logic         wave;
    logic [31:0]  rdata;
  } scid_ctl_state_t;

  scid_ctl_state_t s_q;
  scid_ctl_state_t s_d;

  localparam logic [22:0] MIN_PH = 23'(scid_pkg::MIN_PHASE_CYC);
  localparam logic [22:0] ONE    = 23'h000001;

  // Clamp the high time so both phases stay at least the minimum.
  function automatic logic [22:0] scid_hi_eff(input logic [22:0] p,
                                              input logic [22:0] h);
    if (p < (MIN_PH << 1)) begin
      scid_hi_eff = MIN_PH;
    end else if (h < MIN_PH) begin
      scid_hi_eff = MIN_PH;
    end else if (h > p - MIN_PH) begin
      scid_hi_eff = p - MIN_PH;
    end else begin
      scid_hi_eff = h;
    end
  endfunction : scid_hi_eff

  logic [22:0] hi_eff;
  logic [22:0] lo_eff;

  // ****************************************************************
  // Registers and waveform generator.
  // ****************************************************************
  always_comb begin
    s_d    = s_q;
    hi_eff = scid_hi_eff(s_q.per, s_q.hi);
    lo_eff = (s_q.per > hi_eff + MIN_PH) ? s_q.per - hi_eff : MIN_PH;
    if (i_wr) begin
      case (i_addr)
        scid_pkg::REG_CTRL:   s_d.ctrl = i_wdata[3:0];
        scid_pkg::REG_PERIOD: s_d.per  = i_wdata[22:0];
        scid_pkg::REG_HIGH:   s_d.hi   = i_wdata[22:0];
        default:              s_d.ctrl = s_q.ctrl;
      endcase
    end
    s_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        scid_pkg::REG_CTRL:   s_d.rdata = {28'h0, s_q.ctrl};
        scid_pkg::REG_PERIOD: s_d.rdata = {9'h0, s_q.per};
        scid_pkg::REG_HIGH:   s_d.rdata = {9'h0, s_q.hi};
        default:              s_d.rdata = {30'h0, s_q.wave,
                                           link.fb_status};
      endcase
    end
    // Phase ends compare against the current registers, so a write can cut or stretch the phase in progress.
    s_d.cnt = s_q.cnt + ONE;
    case (s_q.st)
      ST_STATIC: begin
        s_d.wave = s_q.ctrl[scid_pkg::CTRL_LEVEL];
        s_d.cnt  = ONE;
        if (s_q.ctrl[scid_pkg::CTRL_RUN]) begin
          s_d.st   = ST_HIGH;
          s_d.wave = 1'b1;
        end
      end
      ST_HIGH: begin
        if (s_q.cnt >= hi_eff) begin
          s_d.st   = ST_LOW;
          s_d.wave = 1'b0;
          s_d.cnt  = ONE;
        end
      end
      ST_LOW: begin
        if (s_q.cnt >= lo_eff) begin
          s_d.cnt = ONE;
          if (s_q.ctrl[scid_pkg::CTRL_RUN]) begin
            s_d.st   = ST_HIGH;
            s_d.wave = 1'b1;
          end else begin
            s_d.st = ST_STATIC;
          end
        end
      end
      default: begin
        s_d.st = ST_STATIC;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      s_q       <= '0;
      s_q.st    <= ST_STATIC;
      s_q.ctrl  <= scid_pkg::CTRL_RST;
      s_q.per   <= scid_pkg::PERIOD_RST;
      s_q.hi    <= scid_pkg::HIGH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata     = s_q.rdata;
  assign link.enable = s_q.ctrl[scid_pkg::CTRL_EN];
  assign link.sel_a  = s_q.ctrl[scid_pkg::CTRL_DIR];
  assign link.wave   = s_q.wave;

endmodule : scid_controller

// ---- testbench/scid_assertions.sv ----
// ****************************************************************
// Link and output checks for the command decoder pair.
// ****************************************************************
module scid_assertions #(
  parameter int unsigned OFF_CYC = 200, // Waveform loss time.
  parameter int unsigned DIS_CYC = 20   // Disable time.
) (
  input wire logic                 i_clk_sys,  // Clock.
  input wire logic                 i_reset_n,  // Reset.
  input wire logic                 enable,     // Enable line.
  input wire logic                 sel_a,      // Select line.
  input wire logic                 wave,       // Waveform line.
  input wire logic                 fb_status,  // Feedback line.
  input wire logic signed [15:0]   o_torque,   // Device torque.
  input wire logic                 o_energized,// Device energized.
  input wire scid_pkg::scid_mode_t i_mode      // Device mode.
);
  localparam int DIS_LIM = DIS_CYC + 3;
  localparam int OFF_LIM = OFF_CYC + 3;
  logic        wave_q;
  logic [15:0] run_q;
  logic        fell_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  // Length of the current waveform level; saturates so loss stays seen.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      wave_q <= 1'b0;
      run_q  <= 16'h0000;
      fell_q <= 1'b0;
    end else begin
      wave_q <= wave;
      if (wave != wave_q) begin
        run_q <= 16'h0001;
      end else if (run_q != 16'hffff) begin
        run_q <= run_q + 16'h0001;
      end
      if (wave_q && !wave) begin
        fell_q <= 1'b1;
      end
    end
  end

  AST_HIGH_PHASE: assert property (
    (wave_q && !wave) |-> run_q >= 16'h001e)
    else $error("waveform high phase too short");
  // The first low phase after reset is short by nature, so skip it.
  AST_LOW_PHASE: assert property (
    (!wave_q && wave && fell_q) |-> run_q >= 16'h001e)
    else $error("waveform low phase too short");
  AST_LOSS_ZERO: assert property (
    (32'(run_q) > OFF_LIM) |-> o_torque == 16'h0000)
    else $error("torque held after waveform loss");
  AST_DIS_ZERO: assert property (
    (!enable && i_mode != scid_pkg::MODE_SPIN) |=> o_torque == 16'h0000)
    else $error("torque while disabled");
  AST_DEENERGIZE: assert property (
    ($fell(enable) && i_mode != scid_pkg::MODE_SPIN)
    |-> ##[1:DIS_LIM] (!o_energized || enable))
    else $error("motor not de-energized in time");
  AST_SPIN_ON: assert property (
    (i_mode == scid_pkg::MODE_SPIN && $past(i_mode) == scid_pkg::MODE_SPIN
     && $past(i_reset_n)) |-> o_energized)
    else $error("spin mode not energized");
  AST_FB_ENERGY: assert property (
    fb_status |-> (o_energized || $past(o_energized)))
    else $error("feedback high while de-energized");
  AST_SELVEL_NO_TQ: assert property (
    (i_mode == scid_pkg::MODE_SELVEL
     && $past(i_mode) == scid_pkg::MODE_SELVEL) |-> o_torque == 16'h0000)
    else $error("torque in velocity mode");

  // Main scenarios reached.
  COV_BIP_TQ: cover property (
    i_mode == scid_pkg::MODE_BIPOLAR && o_torque != 16'h0000);
  COV_DROP: cover property ($fell(o_energized));
  COV_FB: cover property (fb_status);
endmodule : scid_assertions

// ---- testbench/servo_command_input_decoder_test.sv ----
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); \
  end \
end

module servo_command_input_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus, design pair and checks.
  // ****************************************************************
  logic                       i_clk_sys   = 1'b0;
  logic                       i_reset_n   = 1'b0;
  logic [1:0]                 i_addr      = 2'h0;
  logic [31:0]                i_wdata     = 32'h0;
  logic                       i_wr        = 1'b0;
  logic                       i_rd        = 1'b0;
  logic [31:0]                o_rdata;
  scid_pkg::scid_mode_t       i_mode      = scid_pkg::MODE_BIPOLAR;
  logic [9:0]                 i_deadband  = 10'h033;
  logic [3:0][15:0]           i_sel_vel   = '0;
  logic [15:0]                i_spin_vel  = 16'h0000;
  logic [15:0]                i_accel     = 16'h000a;
  logic signed [15:0]         o_torque;
  logic signed [15:0]         o_velocity;
  logic                       o_energized;
  logic signed [15:0]         v;
  int n_mismatch  = 0;
  int comparisons = 0;
  int cycles      = 0;
  int hs[5] = '{40, 80, 88, 120, 40};
  int ds[5] = '{51, 51, 51, 51, 102};

  scid_link_if link ();
  scid_controller i_scid_controller (.i_clk_sys, .i_reset_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .link(link.controller));
  scid_device #(.OFF_CYC(200), .DIS_CYC(20)) i_scid_device (.i_clk_sys,
    .i_reset_n, .i_mode, .i_deadband, .i_sel_vel, .i_spin_vel, .i_accel,
    .link(link.device), .o_torque, .o_velocity, .o_energized);
  scid_assertions #(.OFF_CYC(200), .DIS_CYC(20)) i_scid_assertions (
    .i_clk_sys, .i_reset_n, .enable(link.enable), .sel_a(link.sel_a),
    .wave(link.wave), .fb_status(link.fb_status), .o_torque, .o_energized,
    .i_mode);

  // Clock at 100 MHz.
  always #5 i_clk_sys = ~i_clk_sys;

  // A hang is cut short and counted as a mismatch.
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      $display("timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc

  // One-cycle write strobe; the next call lets an edge pass first.
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  // Waveform of per cycles; 800 cycles, five periods of 160, settle the measurement.
  task automatic drive(input scid_pkg::scid_mode_t m, input logic [31:0] c,
                       input int per, input int hi);
    wr(scid_pkg::REG_PERIOD, 32'(per));
    wr(scid_pkg::REG_HIGH, 32'(hi));
    wr(scid_pkg::REG_CTRL, c);
    i_mode <= m;
    cyc(800);
  endtask : drive

  // Bipolar torque: zero inside the deadband, full scale at the ends.
  function automatic logic [15:0] bip(input int hi, input int per,
                                      input int db);
    int d;
    int o;
    d = hi * 1024 / per;
    o = ((d > 512) ? d - 512 : 512 - d) - db;
    if (o <= 0) begin
      return 16'h0000;
    end
    o = o * 32767 / (512 - db);
    return 16'((d < 512) ? o : -o);
  endfunction : bip

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    logic [31:0] r;
    repeat (6) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(scid_pkg::REG_PERIOD, r);
    `CHK("period reset", 32'h000003e8, r)
    for (int i = 0; i < 5; i++) begin
      i_deadband <= 10'(ds[i]);
      drive(scid_pkg::MODE_BIPOLAR, 32'h5, 160, hs[i]);
      `CHK("bipolar torque", bip(hs[i], 160, ds[i]), o_torque)
    end
    wr(scid_pkg::REG_CTRL, 32'h1);
    cyc(400);
    `CHK("static low", 16'h0000, o_torque)
    drive(scid_pkg::MODE_BIPOLAR, 32'h5, 160, 40);
    wr(scid_pkg::REG_CTRL, 32'h9);
    cyc(400);
    `CHK("static high", 16'h0000, o_torque)
    $display("test bipolar done");
    for (int d = 0; d < 2; d++) begin
      drive(scid_pkg::MODE_UNIPOLAR, 32'h5 | 32'(d << 1), 160, 40);
      `CHK("unipolar torque", 16'(d ? 8191 : -8191), o_torque)
      drive(scid_pkg::MODE_FREQ, 32'h5 | 32'(d << 1), 160, 40);
      `CHK("freq torque", 16'(d ? 29080 : -29080), o_torque)
    end
    // A period of 143 cycles stays just inside the top pulse rate.
    drive(scid_pkg::MODE_FREQ, 32'h7, 143, 72);
    `CHK("freq top", 16'h7f19, o_torque)
    `CHK("energized", 1'b1, o_energized)
    // Run drops too, so the waveform is quiet before velocity select.
    wr(scid_pkg::REG_CTRL, 32'h0);
    cyc(2);
    `CHK("disabled torque", 16'h0000, o_torque)
    cyc(23);
    `CHK("de-energized", 1'b0, o_energized)
    cyc(200);
    $display("test torque modes done");
    // Velocity three is zero so the controller can stop the motor.
    i_sel_vel <= {16'h0000, 16'hfe0c, 16'h03e8, 16'h0064};
    i_mode <= scid_pkg::MODE_SELVEL;
    wr(scid_pkg::REG_CTRL, 32'h3);
    cyc(20);
    v = o_velocity;
    wr(scid_pkg::REG_CTRL, 32'h9);
    cyc(4);
    `CHK("retarget", 1'b1, 1'(o_velocity < v))
    cyc(200);
    `CHK("velocity idx2", 16'hfe0c, o_velocity)
    wr(scid_pkg::REG_CTRL, 32'h3);
    cyc(200);
    `CHK("velocity idx1", 16'h03e8, o_velocity)
    wr(scid_pkg::REG_CTRL, 32'hb);
    cyc(200);
    `CHK("velocity stop", 16'h0000, o_velocity)
    $display("test selected velocity done");
    i_spin_vel <= 16'h02bc;
    i_mode <= scid_pkg::MODE_SPIN;
    wr(scid_pkg::REG_CTRL, 32'h0);
    cyc(200);
    `CHK("spin velocity", 16'h02bc, o_velocity)
    `CHK("spin energized", 1'b1, o_energized)
    rd(scid_pkg::REG_STATUS, r);
    `CHK("status at speed", 32'h00000001, r)
    $display("test spin done");
    tally_and_finish();
  end
endmodule : servo_command_input_decoder_test
